// ===== dec_comp_regs.vh
`ifndef DEC_COMP_REGS_VH
`define DEC_COMP_REGS_VH
`define OPC_MSB        13
`define OPC_LSB        8
`define DEST_BIT       7
`define ADDR_MSB       6
`define OPC_DEC        6'h03
`define OPC_INV        6'h09
`define OPC_DECSKIP    6'h0b
`define W_RESET        8'h00
`define Z_RESET        1'h0
`endif

// ===== decrement_complement_exec.v
`timescale 1ns/10ps
`default_nettype none
`include "dec_comp_regs.vh"

// Contract
// - skip-decrement subtracts one, skips on zero
// - destination zero writes accumulator, register kept
// - destination one writes back source register
// - skip cancels the prefetched next instruction
// - skipping takes two cycles, else one
// - plain decrement updates zero, one cycle
// - invert complements bits, updates zero
// - seven-bit address, one destination bit
module decrement_complement_exec (
   input  wire        CLK_I,
   input  wire        SYS_RST_I,
   input  wire        INSTR_VALID_I,
   input  wire [13:0] INSTR_I,
   input  wire [7:0]  REG_DATA_I,
   output reg  [6:0]  REG_ADDR_O,
   output reg  [7:0]  REG_WDATA_O,
   output reg         REG_WE_O,
   output reg  [7:0]  W_O,
   output reg         Z_O,
   output reg         SKIP_O,
   output reg         NOP_CYCLE_O,
   output reg         BUSY_O
);

   // a skip leaves exactly one later slot to throw away
   localparam [0:0] ST_RUN    = 1'b0;
   localparam [0:0] ST_SQUASH = 1'b1;

   // instruction fields
   wire [5:0]       opcode;
   wire             dest;
   wire [6:0]       addr;

   // decode
   wire             is_dec;
   wire             is_inv;
   wire             is_decskip;
   wire             is_ours;
   wire             exec;
   wire             drop;
   wire             act;
   wire             take_skip;

   // datapath; operand comes combinationally from the register file
   wire [7:0]       diff;
   wire [7:0]       inverted;
   wire [7:0]       result;
   wire             diff_zero;
   wire             result_zero;

   // state and next values
   reg  [0:0]       state;
   reg  [0:0]       next_state;
   reg  [6:0]       next_addr;
   reg  [7:0]       next_wdata;
   reg              next_we;
   reg  [7:0]       next_w;
   reg              next_z;
   reg              next_skip;
   reg              next_nop;
   reg              next_busy;

   genvar           gi;

   assign opcode      = INSTR_I[`OPC_MSB:`OPC_LSB];
   assign dest        = INSTR_I[`DEST_BIT];
   assign addr        = INSTR_I[`ADDR_MSB:0];
   assign is_dec      = (opcode == `OPC_DEC);
   assign is_inv      = (opcode == `OPC_INV);
   assign is_decskip  = (opcode == `OPC_DECSKIP);
   assign is_ours     = is_dec | is_inv | is_decskip;
   // a squashed slot is a no-op whatever its encoding
   assign exec        = INSTR_VALID_I & (state == ST_RUN);
   assign drop        = INSTR_VALID_I & (state == ST_SQUASH);
   assign act         = exec & is_ours;
   assign diff        = REG_DATA_I - 8'h01;
   assign diff_zero   = (diff == 8'h00);
   assign take_skip   = act & is_decskip & diff_zero;
   assign result      = is_inv ? inverted : diff;
   assign result_zero = (result == 8'h00);

   // per-bit inversion
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_inv
         assign inverted[gi] = ~REG_DATA_I[gi];
      end
   endgenerate

   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (take_skip) begin
               next_state = ST_SQUASH;
            end
         end
         ST_SQUASH: begin
            // idle gaps keep the squash pending
            if (INSTR_VALID_I) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always @* begin
      next_addr  = REG_ADDR_O;
      next_wdata = REG_WDATA_O;
      next_we    = 1'b0;
      next_w     = W_O;
      next_z     = Z_O;
      next_skip  = 1'b0;
      next_busy  = 1'b0;
      next_nop   = drop;
      if (act) begin
         next_addr  = addr;
         // result shown for accumulator writes too; strobe stays low
         next_wdata = result;
         if (dest) begin
            next_we = 1'b1;
         end else begin
            next_w = result;
         end
         // skip-decrement keeps status untouched
         if (!is_decskip) begin
            next_z = result_zero;
         end
         if (take_skip) begin
            next_skip = 1'b1;
            next_busy = 1'b1;
         end
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_ADDR_O <= 7'h00;
      end else begin
         REG_ADDR_O <= next_addr;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_WDATA_O <= 8'h00;
      end else begin
         REG_WDATA_O <= next_wdata;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         REG_WE_O <= 1'b0;
      end else begin
         REG_WE_O <= next_we;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         W_O <= `W_RESET;
      end else begin
         W_O <= next_w;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         Z_O <= `Z_RESET;
      end else begin
         Z_O <= next_z;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SKIP_O <= 1'b0;
      end else begin
         SKIP_O <= next_skip;
      end
   end

   // pulses for the discarded slot, no register or flag change there
   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         NOP_CYCLE_O <= 1'b0;
      end else begin
         NOP_CYCLE_O <= next_nop;
      end
   end

   always @(posedge CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         BUSY_O <= 1'b0;
      end else begin
         BUSY_O <= next_busy;
      end
   end

endmodule
`default_nettype wire

// ===== dc_rf.sv
`timescale 1ns/10ps
`default_nettype none
module dc_rf(input wire logic c,w,input wire logic[6:0]r,a,
input wire logic[7:0]d,output logic[7:0]q);
logic[7:0]m[128];
initial for(int i=0;i<128;i++)m[i]=8'(i);
assign q=m[r];
always@(posedge c)if(w)m[a]<=d;
endmodule
`default_nettype wire

// ===== dc_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dc_sva(input wire logic CLK_I,SYS_RST_I,INSTR_VALID_I,Z_O,
input wire logic REG_WE_O,SKIP_O,BUSY_O,NOP_CYCLE_O,
input wire logic[13:0]INSTR_I,
input wire logic[7:0]REG_DATA_I,W_O,REG_WDATA_O);
default clocking@(posedge CLK_I);endclocking
default disable iff(SYS_RST_I);
logic p;
wire v=INSTR_VALID_I,a=v&!(p|SKIP_O),d=INSTR_I[7],b=REG_DATA_I==1;
wire[5:0]o=INSTR_I[13:8];
always@(posedge CLK_I,posedge SYS_RST_I)p<=!SYS_RST_I&(SKIP_O|p)&!v;
sequence s_q;(SKIP_O|p)&v;endsequence
property p_q;s_q|=>NOP_CYCLE_O&!REG_WE_O;endproperty
a_q:assert property(p_q)else $error("no squash");
property p_s;a&o==11&b|=>SKIP_O&BUSY_O&REG_WDATA_O==0;endproperty
a_s:assert property(p_s)else $error("no skip");
property p_n;a&o==11&!b|=>!SKIP_O&!BUSY_O;endproperty
a_n:assert property(p_n)else $error("bad skip");
property p_0;a&o inside{3,9,11}&!d|=>!REG_WE_O;endproperty
a_0:assert property(p_0)else $error("wrote");
property p_1;a&o inside{3,9,11}&d|=>REG_WE_O&$stable(W_O);endproperty
a_1:assert property(p_1)else $error("no write");
property p_d;a&o==3|=>REG_WDATA_O==$past(REG_DATA_I)-8'h01;endproperty
a_d:assert property(p_d)else $error("bad dec");
property p_i;a&o==9|=>(REG_WDATA_O==~$past(REG_DATA_I))&&
(Z_O==(REG_WDATA_O==0));endproperty
a_i:assert property(p_i)else $error("bad inv");
property p_z;a&o==11|=>$stable(Z_O);endproperty
a_z:assert property(p_z)else $error("z moved");
property p_w;a&o inside{3,9,11}&!d|=>W_O==REG_WDATA_O;endproperty
a_w:assert property(p_w)else $error("bad acc");
endmodule
bind decrement_complement_exec dc_sva i_sva(.*);
`default_nettype wire

// ===== decrement_complement_exec_tb.sv
`timescale 1ns/10ps
`default_nettype none
module decrement_complement_exec_tb;
`define C(x,y) begin n_compared++;if((x)!==(y))begin err_count++;\
$display("FAIL %0t mismatch",$time);end end
logic CLK_I=0,SYS_RST_I=1,INSTR_VALID_I=0;logic[13:0]INSTR_I=0;
wire[7:0]REG_DATA_I,W_O,REG_WDATA_O;wire[6:0]REG_ADDR_O;
wire REG_WE_O,Z_O,SKIP_O,NOP_CYCLE_O,BUSY_O;
int err_count=0,n_compared=0,cyc=0;
logic[24:0]t[7]='{{14'h0913,11'h760},{14'h0385,11'h762},{14'h0305,
11'h018},{14'h097f,11'h400},{14'h0301,11'h004},{14'h0b02,11'h00c},
{14'h0a02,11'h00c}};
decrement_complement_exec i_dut(.*);
dc_rf i_rf(.c(CLK_I),.w(REG_WE_O),.r(INSTR_I[6:0]),.a(REG_ADDR_O),
.d(REG_WDATA_O),.q(REG_DATA_I));
always #2 CLK_I=~CLK_I;
always@(posedge CLK_I)if(++cyc>99)begin err_count++;final_report;end
task final_report;if(err_count==0&&n_compared>0)
$display("No errors found");
else
$display("Errors were found");
$finish;endtask
task run(logic[24:0]r);@(posedge CLK_I)INSTR_VALID_I<=1;INSTR_I<=r[24:11];
@(posedge CLK_I)INSTR_VALID_I<=0;#1`C({W_O,Z_O,REG_WE_O,SKIP_O},r[10:0])
endtask
initial begin
repeat(12)@(posedge CLK_I);SYS_RST_I<=0;`C({W_O,Z_O,SKIP_O},9'h0)
foreach(t[i])run(t[i]);
@(posedge CLK_I)INSTR_VALID_I<=1;INSTR_I<=14'h0b81;
@(posedge CLK_I)INSTR_I<=14'h0300;
#1`C({W_O,Z_O,REG_WE_O,SKIP_O,BUSY_O,REG_ADDR_O,REG_WDATA_O},
27'h00f8100)
@(posedge CLK_I)INSTR_VALID_I<=0;
#1`C({NOP_CYCLE_O,W_O,Z_O,REG_WE_O},11'h406)
run({14'h0301,11'h7f8});final_report;end
endmodule
`default_nettype wire
